// ==== inc/fifo_host_pkg.sv ====
/*
 Shared constants and types of the handshake-port host controller.
 Assumes a 125 MHz clock; all times are whole clock cycles.
*/
package fifo_host_pkg;
	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX = 8'h04;
	localparam logic [7:0] OFS_RX = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_P1_CMD = 8'h10;
	localparam logic [7:0] OFS_P1_DATA = 8'h14;

	localparam int unsigned CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_TWO_WIRE = 1;
	localparam int unsigned CTRL_TX_DIR = 2;
	localparam int unsigned CTRL_DRIVE_DIR = 3;
	localparam int unsigned CTRL_CLEAR = 4;
	localparam int unsigned CTRL_GP_IN = 5;

	localparam int unsigned STAT_TX_PEND = 0;
	localparam int unsigned STAT_RX_VALID = 1;
	localparam int unsigned STAT_EMPTY = 2;
	localparam int unsigned STAT_FULL = 3;
	localparam int unsigned STAT_READY_AVAIL = 4;
	localparam int unsigned STAT_GP_GENERAL_OUTPUT_0 = 5;
	localparam int unsigned STAT_GP_GENERAL_OUTPUT_3 = 6;
	localparam int unsigned STAT_DIR = 7;
	localparam int unsigned STAT_P1_BUSY = 8;
	localparam int unsigned STAT_CLEAR = 9;
	localparam int unsigned STAT_HS_BUSY = 10;

	localparam int unsigned CMD_SEL_LSB = 0;
	localparam int unsigned CMD_RNW = 8;
	localparam int unsigned CMD_DMA = 9;
	localparam int unsigned CMD_ACK = 10;
	localparam int unsigned CMD_WDATA_LSB = 16;

	localparam int unsigned CNT_W = 4;
	localparam int unsigned SETUP_CYC = 2;
	localparam int unsigned PULSE_CYC = 4;
	localparam int unsigned CLEAR_CYC = 8;
	localparam int unsigned PHASE_CYC = 4;
	localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
	localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYC - 1);
	localparam logic [3:0] CLEAR_LOAD = 4'(CLEAR_CYC);

	localparam int unsigned SYNC_W = 24;
	localparam logic [23:0] SYNC_RESET = 24'h11_0000;

	typedef struct packed {
		logic ack;
		logic dma;
		logic rnw;
		logic [3:0] sel;
		logic [7:0] wdata;
	} p1_cmd_type;

	typedef struct packed {
		logic [7:0] ad_o;
		logic ad_oe;
		logic [3:0] sel;
		logic as_n;
		logic ds_n;
		logic rnw;
		logic cs_n;
		logic ack_n;
		logic dma_n;
	} p1_pins_type;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_WAIT_READY = 3'b001,
		HS_SETUP = 3'b010,
		HS_STROBE = 3'b011,
		HS_WAIT_IDLE = 3'b100
	} hs_state_type;

	typedef enum logic [2:0] {
		P1_IDLE = 3'b000,
		P1_ADDR = 3'b001,
		P1_GAP = 3'b010,
		P1_DATA = 3'b011,
		P1_END = 3'b100
	} p1_state_type;
endpackage

// ==== rtl/pin_sync.sv ====
/*
 Two-flop synchroniser for a bundle of asynchronous pin inputs.
 Assumes each bit is independent; buses must be stable while sampled.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_ff[i] <= RST_VAL[i];
					sync_ff[i] <= RST_VAL[i];
				end else begin
					meta_ff[i] <= din[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign dout = sync_ff;
endmodule

// ==== rtl/bus_cycle_engine.sv ====
/*
 Port-1 bus master: one multiplexed address/data access or one DMA strobe.
 Assumes synchronised inputs and a reset already released synchronously.
*/
`timescale 1ns/1ps
module bus_cycle_engine
	import fifo_host_pkg::*;
#(
	parameter int unsigned PHASE = PHASE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire p1_cmd_type cmd,
	input wire logic [7:0] ad_s,
	input wire logic req_wait_s_n,
	output p1_pins_type pins,
	output logic busy,
	output logic done,
	output logic [7:0] rdata
);
	localparam logic [3:0] PHASE_LAST = 4'(PHASE - 1);

	p1_state_type state_ff;
	p1_state_type nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	p1_cmd_type cmd_ff;
	p1_cmd_type cur;
	p1_pins_type pins_ff;
	p1_pins_type nxt_pins;
	logic [7:0] rdata_ff;

	always_comb begin
		cur = (state_ff == P1_IDLE) ? cmd : cmd_ff;
		nxt_state = state_ff;
		unique case (state_ff)
			P1_IDLE: if (start) nxt_state = cmd.dma ? P1_GAP : P1_ADDR;
			P1_ADDR: if (cnt_ff == PHASE_LAST) nxt_state = P1_GAP;
			// Request low means the device is ready for a DMA byte
			P1_GAP: if (!cmd_ff.dma || !req_wait_s_n) nxt_state = P1_DATA; // RULE20
			// Wait line low stretches the data strobe
			P1_DATA: if (cnt_ff == PHASE_LAST && (cmd_ff.dma || req_wait_s_n)) begin // RULE20
				nxt_state = P1_END;
			end
			P1_END: nxt_state = P1_IDLE;
			default: nxt_state = P1_IDLE;
		endcase
	end

	always_comb begin
		nxt_pins = '{ad_o: 8'h00, ad_oe: 1'b0, sel: cur.sel, as_n: 1'b1, ds_n: 1'b1,
			rnw: cur.rnw, cs_n: 1'b1, ack_n: 1'b1, dma_n: 1'b1}; // RULE18
		unique case (nxt_state)
			P1_ADDR: begin
				nxt_pins.cs_n = 1'b0; // RULE16
				nxt_pins.as_n = 1'b0;
				nxt_pins.ack_n = ~cur.ack;
				nxt_pins.ad_o = {4'h0, cur.sel}; // RULE22 RULE17
				nxt_pins.ad_oe = 1'b1;
			end
			P1_GAP, P1_DATA: begin
				// Chip select outlives the address strobe's rising edge
				nxt_pins.cs_n = cur.dma; // RULE15
				nxt_pins.ack_n = cur.dma | ~cur.ack;
				nxt_pins.ad_o = cur.wdata; // RULE22
				nxt_pins.ad_oe = ~cur.rnw;
				nxt_pins.ds_n = cur.dma | (nxt_state != P1_DATA); // RULE19
				nxt_pins.dma_n = ~cur.dma | (nxt_state != P1_DATA); // RULE21
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= P1_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff) cnt_ff <= '0;
			else if (cnt_ff != PHASE_LAST) cnt_ff <= cnt_ff + 4'd1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_ff <= '{ad_o: 8'h00, ad_oe: 1'b0, sel: 4'h0, as_n: 1'b1, ds_n: 1'b1,
				rnw: 1'b1, cs_n: 1'b1, ack_n: 1'b1, dma_n: 1'b1};
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= '0;
			rdata_ff <= 8'h00;
		end else begin
			if (state_ff == P1_IDLE && start) cmd_ff <= cmd;
			if (state_ff == P1_DATA && nxt_state == P1_END && cmd_ff.rnw) rdata_ff <= ad_s;
		end
	end

	assign pins = pins_ff;
	assign busy = (state_ff != P1_IDLE);
	assign done = (state_ff == P1_END);
	assign rdata = rdata_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_CS_AT_AS_RISE: assert property ($rose(pins_ff.as_n) |-> !pins_ff.cs_n) // RULE15
		else $error("chip select released with address strobe");
	sequence s_addr_phase;
		!pins_ff.as_n && pins_ff.ad_oe;
	endsequence
	AST_ADDR_THEN_DATA: assert property ($fell(pins_ff.ds_n) |-> $past(pins_ff.as_n) // RULE22
		&& !pins_ff.cs_n)
		else $error("data strobe without prior address phase");
	AST_ADDR_ON_BUS: assert property (s_addr_phase |-> pins_ff.ad_o[3:0] == pins_ff.sel) // RULE17
		else $error("address lines differ from register select");
	AST_RNW_STEADY: assert property (!pins_ff.cs_n && !$past(pins_ff.cs_n) // RULE18
		|-> $stable(pins_ff.rnw))
		else $error("direction changed inside a cycle");
	AST_WAIT_STRETCH: assert property (state_ff == P1_DATA && !req_wait_s_n // RULE20
		&& !cmd_ff.dma |=> !pins_ff.ds_n)
		else $error("data strobe ended during wait");
	AST_DMA_AFTER_REQ: assert property ($fell(pins_ff.dma_n) |-> !$past(req_wait_s_n)) // RULE21
		else $error("DMA strobe without request");
endmodule

// ==== rtl/fifo_pin_controller.sv ====
/*
 Host controller for a byte FIFO unit: peer of the handshake port
 (3-wire or 2-wire) and master of the multiplexed register bus, with
 an APB slave for software. Assumes device pins are asynchronous.
*/
// Function
// RULE1: device raises ready when accepting bytes
// RULE2: device drives available low when sending
// RULE3: host drives available low with valid data
// RULE4: host raises accepted after taking a byte
// RULE5: third pin swaps direction with transfer direction
// RULE6: 2-wire: host pulses acknowledge low per byte
// RULE7: device asserts open-drain full flag
// RULE8: device asserts open-drain empty flag
// RULE9: active-low clear discards buffered data
// RULE10: direction pin high means into port
// RULE11: general input drives control bit 0
// RULE12: general output 0 follows control bit 1
// RULE13: general output 3 follows control bit 3
// RULE14: enable low lets device drive data
// RULE15: chip select captured at address strobe rise
// RULE16: address and selects sampled while strobe low
// RULE17: four register selects choose target register
// RULE18: read_not_write high reads, low writes
// RULE19: data strobe times each port-1 transfer
// RULE20: request/wait line: DMA request or wait
// RULE21: DMA strobe pulse moves each DMA byte
// RULE22: bus lines carry address then data
// RULE23: each byte finishes full interlock before next
`timescale 1ns/1ps
module fifo_pin_controller
	import fifo_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] port2_data_i,
	output logic [7:0] port2_data_o,
	output logic port2_data_oe,
	input wire logic ready_avail_i,
	output logic peer_strobe_o,
	input wire logic accept_ready_i,
	output logic accept_ready_o,
	output logic accept_ready_oe,
	input wire logic empty_i,
	input wire logic clear_n_i,
	output logic clear_n_o,
	output logic clear_n_oe,
	input wire logic direction_i,
	output logic direction_o,
	output logic direction_oe,
	output logic general_input_0,
	input wire logic general_output_0,
	input wire logic general_output_3,
	output logic bus_drive_enable_n,
	input wire logic [7:0] muxed_addr_data_i,
	output logic [7:0] muxed_addr_data_o,
	output logic muxed_addr_data_oe,
	output logic [3:0] register_select,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_not_write,
	output logic chip_select_n,
	output logic irq_acknowledge_n,
	output logic dma_strobe_n,
	input wire logic request_or_wait_n
);
	logic rst_meta_ff;
	logic rst_sync_n_ff;
	logic [SYNC_W-1:0] sync_out;
	logic s_ready_avail, s_accept_ready, s_empty, s_clear_n, s_dir, s_gp0, s_gp3, s_req_n;
	logic [7:0] s_p2_data;
	logic [7:0] s_ad;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [CNT_W-1:0] clear_cnt_ff;
	logic clear_drive_ff;
	logic [31:0] prdata_ff;
	logic [31:0] status;
	logic [31:0] rd_word;
	logic wr_en, rd_acc, mapped, flush, p1_start, p1_busy, p1_done;
	logic [7:0] p1_rdata;
	p1_pins_type p1_pins;
	p1_cmd_type p1_cmd;
	hs_state_type state_ff;
	hs_state_type nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic tx_ff, two_ff, nxt_tx, nxt_two, dir_eff;
	logic ready_cond, idle_cond, start_ok, hs_done, rx_take, act_level;
	logic tx_pending_ff, rx_valid_ff;
	logic [7:0] tx_byte_ff;
	logic [7:0] rx_byte_ff;
	logic strobe_ff, ar_o_ff, ar_oe_ff, data_oe_ff, bde_n_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end

	pin_sync #(.W(SYNC_W), .RST_VAL(SYNC_RESET)) u_sync (
		.clk(clk),
		.rst_n(rst_sync_n_ff),
		.din({ready_avail_i, accept_ready_i, empty_i, clear_n_i, direction_i,
			general_output_0, general_output_3, request_or_wait_n,
			port2_data_i, muxed_addr_data_i}),
		.dout(sync_out)
	);
	assign {s_ready_avail, s_accept_ready, s_empty, s_clear_n, s_dir, s_gp0, s_gp3, s_req_n,
		s_p2_data, s_ad} = sync_out;

	// APB slave: zero wait states, error on unmapped offsets
	assign wr_en = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_TX) || (paddr == OFS_RX) ||
		(paddr == OFS_STATUS) || (paddr == OFS_P1_CMD) || (paddr == OFS_P1_DATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	always_comb begin
		status = 32'h0000_0000;
		status[STAT_TX_PEND] = tx_pending_ff;
		status[STAT_RX_VALID] = rx_valid_ff;
		status[STAT_EMPTY] = s_empty; // RULE8
		status[STAT_FULL] = two_ff && s_accept_ready; // RULE7
		status[STAT_READY_AVAIL] = s_ready_avail;
		status[STAT_GP_GENERAL_OUTPUT_0] = s_gp0; // RULE12
		status[STAT_GP_GENERAL_OUTPUT_3] = s_gp3; // RULE13
		status[STAT_DIR] = s_dir;
		status[STAT_P1_BUSY] = p1_busy;
		status[STAT_CLEAR] = !s_clear_n;
		status[STAT_HS_BUSY] = (state_ff != HS_IDLE);
		unique case (paddr)
			OFS_CTRL: rd_word = {26'h000_0000, ctrl_ff};
			OFS_RX: rd_word = {24'h00_0000, rx_byte_ff};
			OFS_STATUS: rd_word = status;
			OFS_P1_DATA: rd_word = {24'h00_0000, p1_rdata};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) prdata_ff <= 32'h0000_0000;
		else if (psel && !penable) prdata_ff <= rd_word;
	end

	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) ctrl_ff <= CTRL_RESET;
		else if (wr_en && paddr == OFS_CTRL) ctrl_ff <= pwdata[CTRL_W-1:0];
	end

	// Clear pulse drives the pin low for a fixed time
	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			clear_cnt_ff <= '0;
			clear_drive_ff <= 1'b0;
		end else begin
			if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLEAR]) clear_cnt_ff <= CLEAR_LOAD;
			else if (clear_cnt_ff != '0) clear_cnt_ff <= clear_cnt_ff - 4'd1;
			clear_drive_ff <= (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLEAR]) ||
				(clear_cnt_ff > 4'd1); // RULE9
		end
	end
	assign flush = clear_drive_ff || !s_clear_n; // RULE9

	assign p1_cmd = '{ack: pwdata[CMD_ACK], dma: pwdata[CMD_DMA], rnw: pwdata[CMD_RNW],
		sel: pwdata[CMD_SEL_LSB+:4], wdata: pwdata[CMD_WDATA_LSB+:8]};
	assign p1_start = wr_en && paddr == OFS_P1_CMD && !p1_busy;

	bus_cycle_engine #(.PHASE(PHASE_CYC)) u_bus (
		.clk(clk),
		.rst_n(rst_sync_n_ff),
		.start(p1_start),
		.cmd(p1_cmd),
		.ad_s(s_ad),
		.req_wait_s_n(s_req_n),
		.pins(p1_pins),
		.busy(p1_busy),
		.done(p1_done),
		.rdata(p1_rdata)
	);

	// Handshake port sequencing
	assign dir_eff = ctrl_ff[CTRL_DRIVE_DIR] ? ctrl_ff[CTRL_TX_DIR] : s_dir; // RULE10
	assign nxt_tx = (state_ff == HS_IDLE) ? dir_eff : tx_ff;
	assign nxt_two = (state_ff == HS_IDLE) ? ctrl_ff[CTRL_TWO_WIRE] : two_ff;
	assign start_ok = ctrl_ff[CTRL_EN] && (dir_eff ? tx_pending_ff : !rx_valid_ff);
	assign ready_cond = tx_ff ? s_ready_avail : !s_ready_avail; // RULE1 RULE2
	assign idle_cond = two_ff ? (tx_ff ? !s_ready_avail : s_ready_avail)
		: (!tx_ff ? 1'b1 : !s_accept_ready);
	assign hs_done = (state_ff == HS_WAIT_IDLE) && idle_cond && !flush;
	assign rx_take = (state_ff == HS_WAIT_READY) && !tx_ff && ready_cond && !flush;
	// Active level of the strobe pin by mode and direction
	assign act_level = !nxt_two && !nxt_tx;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			HS_IDLE: if (start_ok) nxt_state = HS_WAIT_READY;
			HS_WAIT_READY: if (ready_cond) nxt_state = tx_ff ? HS_SETUP : HS_STROBE;
			HS_SETUP: if (cnt_ff == SETUP_LAST) nxt_state = HS_STROBE;
			HS_STROBE: begin
				if (two_ff) begin
					if (cnt_ff == PULSE_LAST) nxt_state = HS_WAIT_IDLE; // RULE6
				end else if (tx_ff ? s_accept_ready : s_ready_avail) begin // RULE5
					nxt_state = HS_WAIT_IDLE;
				end
			end
			HS_WAIT_IDLE: if (idle_cond) nxt_state = HS_IDLE; // RULE23
			default: nxt_state = HS_IDLE;
		endcase
		if (flush) nxt_state = HS_IDLE;
	end

	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			state_ff <= HS_IDLE;
			cnt_ff <= '0;
			tx_ff <= 1'b0;
			two_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tx_ff <= nxt_tx; // RULE10
			two_ff <= nxt_two;
			if (nxt_state != state_ff) cnt_ff <= '0;
			else if (cnt_ff != PULSE_LAST) cnt_ff <= cnt_ff + 4'd1;
		end
	end

	// Software loads and unloads bytes; hardware set wins over the clear
	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			tx_pending_ff <= 1'b0;
			tx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
		end else begin
			if (wr_en && paddr == OFS_TX && !tx_pending_ff && !flush) begin
				tx_pending_ff <= 1'b1;
				tx_byte_ff <= pwdata[7:0];
			end else if (flush || (hs_done && tx_ff)) begin
				tx_pending_ff <= 1'b0;
			end
			if (rx_take) begin
				rx_valid_ff <= 1'b1;
				rx_byte_ff <= s_p2_data; // RULE2
			end else if (flush || (rd_acc && paddr == OFS_RX)) begin
				rx_valid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			strobe_ff <= 1'b1;
			ar_o_ff <= 1'b0;
			ar_oe_ff <= 1'b0;
			data_oe_ff <= 1'b0;
			bde_n_ff <= 1'b1;
		end else begin
			strobe_ff <= (nxt_state == HS_STROBE) ? act_level : !act_level; // RULE3 RULE4 RULE6
			ar_oe_ff <= !nxt_two && !nxt_tx; // RULE5
			ar_o_ff <= (nxt_state == HS_WAIT_READY) && !nxt_tx; // RULE5
			data_oe_ff <= nxt_tx && (nxt_state == HS_SETUP || nxt_state == HS_STROBE ||
				nxt_state == HS_WAIT_IDLE); // RULE3
			bde_n_ff <= nxt_tx; // RULE14
		end
	end

	assign peer_strobe_o = strobe_ff;
	assign accept_ready_o = ar_o_ff;
	assign accept_ready_oe = ar_oe_ff;
	assign port2_data_o = tx_byte_ff;
	assign port2_data_oe = data_oe_ff;
	assign bus_drive_enable_n = bde_n_ff;
	assign clear_n_o = 1'b0;
	assign clear_n_oe = clear_drive_ff;
	assign direction_o = ctrl_ff[CTRL_TX_DIR];
	assign direction_oe = ctrl_ff[CTRL_DRIVE_DIR];
	assign general_input_0 = ctrl_ff[CTRL_GP_IN]; // RULE11
	assign muxed_addr_data_o = p1_pins.ad_o;
	assign muxed_addr_data_oe = p1_pins.ad_oe;
	assign register_select = p1_pins.sel;
	assign address_strobe_n = p1_pins.as_n;
	assign data_strobe_n = p1_pins.ds_n;
	assign read_not_write = p1_pins.rnw;
	assign chip_select_n = p1_pins.cs_n;
	assign irq_acknowledge_n = p1_pins.ack_n;
	assign dma_strobe_n = p1_pins.dma_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n_ff);

	sequence s_send_blocked;
		state_ff == HS_WAIT_READY && tx_ff && !s_ready_avail && !flush;
	endsequence
	sequence s_setup_end;
		state_ff == HS_SETUP && cnt_ff == SETUP_LAST && !flush;
	endsequence
	AST_TX_WAITS_READY: assert property (s_send_blocked |=> state_ff == HS_WAIT_READY) // RULE1
		else $error("byte sent before device was ready");
	AST_AVAIL_AFTER_SETUP: assert property (s_setup_end ##1 (!two_ff) // RULE3
		|-> !peer_strobe_o && port2_data_oe)
		else $error("available not asserted after data setup");
	AST_ACCEPT_AFTER_TAKE: assert property (rx_take && !two_ff |=> peer_strobe_o // RULE4
		&& rx_valid_ff && !accept_ready_o)
		else $error("accepted not raised after taking byte");
	AST_ACK_PULSE: assert property (two_ff && $fell(peer_strobe_o) && !flush // RULE6
		|-> (!peer_strobe_o && !flush) [*3] ##1 (!peer_strobe_o || flush) ##1 peer_strobe_o)
		else $error("acknowledge pulse width wrong");
	AST_CLEAR_FLUSH: assert property (clear_drive_ff |=> !rx_valid_ff && state_ff == HS_IDLE) // RULE9
		else $error("clear did not flush transfer");
	AST_DIR_STEADY: assert property (state_ff != HS_IDLE && $past(state_ff) != HS_IDLE // RULE10
		|-> $stable(tx_ff))
		else $error("direction changed during transfer");
	AST_NO_BUS_FIGHT: assert property (port2_data_oe |-> bus_drive_enable_n) // RULE14
		else $error("host drives data while device enabled");
	AST_INTERLOCK: assert property (state_ff == HS_WAIT_IDLE // RULE23
		|=> state_ff == HS_WAIT_IDLE || state_ff == HS_IDLE)
		else $error("new byte started before interlock ended");
endmodule

// ==== test/fifo_port_device_model.sv ====
/*
 Behavioural model of the byte FIFO device: 3-wire handshake port and port-1 bus.
 Assumes the host controller drives all host-side pins; 2-wire receive is not modelled.
*/
`timescale 1ns/1ps
module fifo_port_device_model #(
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] port2_data_o,
	input wire logic peer_strobe_o,
	input wire logic accept_ready_o,
	input wire logic accept_ready_oe,
	input wire logic clear_n_o,
	input wire logic clear_n_oe,
	input wire logic direction_o,
	input wire logic direction_oe,
	input wire logic general_input_0,
	input wire logic bus_drive_enable_n,
	input wire logic [7:0] muxed_addr_data_o,
	input wire logic [3:0] register_select,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic chip_select_n,
	output logic [7:0] port2_data_i,
	output logic ready_avail_i,
	output logic accept_ready_i,
	output logic empty_i,
	output logic clear_n_i,
	output logic direction_i,
	output logic general_output_0,
	output logic general_output_3,
	output logic [7:0] muxed_addr_data_i,
	output logic request_or_wait_n
);
	logic [7:0] q[$];
	logic [7:0] cr3, dout, ad_out;
	logic busy, ad_drv, cs_lat;
	logic [2:0] wcnt;
	logic [3:0] sel_lat;
	// Released data buses show the inverse of the last value; released clear and direction read high
	assign port2_data_i = bus_drive_enable_n ? ~dout : dout;
	assign muxed_addr_data_i = ad_drv ? ad_out : ~ad_out;
	assign clear_n_i = clear_n_oe ? clear_n_o : 1'b1;
	assign direction_i = direction_oe ? direction_o : 1'b1;
	assign general_output_0 = cr3[1];
	assign general_output_3 = cr3[3];
	// Idle: DMA request low; each data strobe opens with a wait
	assign request_or_wait_n = !data_strobe_n && wcnt == 3'd0;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n || !clear_n_i) begin
			q.delete();
			ready_avail_i <= 1'b0;
			accept_ready_i <= 1'b0;
			busy <= 1'b0;
			empty_i <= 1'b1;
			dout <= 8'h00;
		end else if (direction_i) begin
			if (!busy && ready_avail_i && !peer_strobe_o) begin
				q.push_back(port2_data_o);
				ready_avail_i <= 1'b0;
				accept_ready_i <= 1'b1;
				busy <= 1'b1;
			end else if (busy && peer_strobe_o) begin
				accept_ready_i <= 1'b0;
				busy <= 1'b0;
			end else if (!busy) begin
				ready_avail_i <= (q.size() < DEPTH);
			end
			empty_i <= (q.size() == 0);
		end else begin
			accept_ready_i <= 1'b0;
			if (!busy && q.size() > 0 && accept_ready_oe && accept_ready_o && !peer_strobe_o) begin
				dout <= q[0];
				ready_avail_i <= 1'b0;
				busy <= 1'b1;
			end else if (busy && peer_strobe_o) begin
				void'(q.pop_front());
				ready_avail_i <= 1'b1;
				busy <= 1'b0;
			end else if (!busy) begin
				ready_avail_i <= 1'b1;
			end
			empty_i <= (q.size() == 0);
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cr3 <= 8'h00;
			ad_drv <= 1'b0;
			ad_out <= 8'h00;
			cs_lat <= 1'b0;
			sel_lat <= 4'h0;
			wcnt <= 3'd0;
		end else begin
			if (data_strobe_n) wcnt <= 3'd6;
			else if (wcnt != 3'd0) wcnt <= wcnt - 3'd1;
			if (!address_strobe_n) begin
				sel_lat <= register_select;
				cs_lat <= !chip_select_n;
			end
			ad_drv <= !data_strobe_n && cs_lat && read_not_write;
			if (!data_strobe_n && cs_lat && !read_not_write && sel_lat == 4'h3) begin
				cr3 <= muxed_addr_data_o;
			end
			ad_out <= (sel_lat == 4'h3) ? {cr3[7:1], general_input_0} : 8'h00;
		end
	end
endmodule

// ==== test/tb_fifo_pin_controller.sv ====
/*
 Self-checking bench for the handshake-port host controller over APB.
 Assumes the device model on the far side and APB answers before the 64-cycle timeout.
*/
`timescale 1ns/1ps
module tb_fifo_pin_controller
	import fifo_host_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, port2_data_i, port2_data_o, muxed_addr_data_i, muxed_addr_data_o;
	logic [31:0] pwdata, prdata, rd;
	logic port2_data_oe, ready_avail_i, peer_strobe_o, accept_ready_i, accept_ready_o;
	logic accept_ready_oe, empty_i, clear_n_i, clear_n_o, clear_n_oe, direction_i;
	logic direction_o, direction_oe, general_input_0, general_output_0, general_output_3;
	logic bus_drive_enable_n, muxed_addr_data_oe, address_strobe_n, data_strobe_n;
	logic read_not_write, chip_select_n, irq_acknowledge_n, dma_strobe_n, request_or_wait_n;
	logic [3:0] register_select;
	logic [31:0] csend, crecv;
	int miscompares = 0;
	int checks_done = 0;
	fifo_pin_controller dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .port2_data_i, .port2_data_o, .port2_data_oe,
		.ready_avail_i, .peer_strobe_o, .accept_ready_i, .accept_ready_o, .accept_ready_oe,
		.empty_i, .clear_n_i, .clear_n_o, .clear_n_oe, .direction_i, .direction_o,
		.direction_oe, .general_input_0, .general_output_0, .general_output_3,
		.bus_drive_enable_n, .muxed_addr_data_i, .muxed_addr_data_o, .muxed_addr_data_oe,
		.register_select, .address_strobe_n, .data_strobe_n, .read_not_write, .chip_select_n,
		.irq_acknowledge_n, .dma_strobe_n, .request_or_wait_n);
	fifo_port_device_model dev_u (.clk, .rst_n, .port2_data_o, .peer_strobe_o,
		.accept_ready_o, .accept_ready_oe, .clear_n_o, .clear_n_oe, .direction_o,
		.direction_oe, .general_input_0, .bus_drive_enable_n, .muxed_addr_data_o,
		.register_select, .address_strobe_n, .data_strobe_n, .read_not_write, .chip_select_n,
		.port2_data_i, .ready_avail_i, .accept_ready_i, .empty_i, .clear_n_i, .direction_i,
		.general_output_0, .general_output_3, .muxed_addr_data_i, .request_or_wait_n);
	initial clk = 1'b0;
	always #4 clk = ~clk;
	function automatic logic [31:0] bit_at(input int i);
		return 32'h0000_0001 << i;
	endfunction
	task automatic summarize();
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[b] !== v && n < 200);
		chk({31'h0000_0000, rd[b]}, {31'h0000_0000, v});
		if (rd[b] !== v)
			summarize();
	endtask
	task automatic p1(input logic [31:0] cmd);
		apb(1'b1, OFS_P1_CMD, cmd);
		poll(STAT_P1_BUSY, 1'b0);
	endtask
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		crecv = bit_at(CTRL_EN) | bit_at(CTRL_DRIVE_DIR) | bit_at(CTRL_GP_IN);
		csend = crecv | bit_at(CTRL_TX_DIR);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(OFS_CTRL, {26'h000_0000, CTRL_RESET});
		rdchk(8'h1C, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, bit_at(CTRL_GP_IN));
		p1(32'h00FF_0005);
		p1(bit_at(CMD_RNW) | 32'h0000_0003);
		rdchk(OFS_P1_DATA, 32'h0000_0001);
		p1(32'h000A_0003);
		poll(STAT_GP_GENERAL_OUTPUT_0, 1'b1);
		poll(STAT_GP_GENERAL_OUTPUT_3, 1'b1);
		p1(bit_at(CMD_RNW) | 32'h0000_0003);
		rdchk(OFS_P1_DATA, 32'h0000_000B);
		p1(bit_at(CMD_DMA));
		apb(1'b1, OFS_CTRL, csend);
		apb(1'b1, OFS_TX, 32'h0000_00A5);
		poll(STAT_TX_PEND, 1'b0);
		poll(STAT_EMPTY, 1'b0);
		apb(1'b1, OFS_CTRL, csend | bit_at(CTRL_CLEAR));
		poll(STAT_EMPTY, 1'b1);
		poll(STAT_CLEAR, 1'b0);
		apb(1'b1, OFS_CTRL, csend);
		apb(1'b1, OFS_TX, 32'h0000_005A);
		apb(1'b1, OFS_TX, 32'h0000_0099);
		poll(STAT_TX_PEND, 1'b0);
		apb(1'b1, OFS_TX, 32'h0000_00C3);
		poll(STAT_TX_PEND, 1'b0);
		apb(1'b1, OFS_CTRL, csend | bit_at(CTRL_TWO_WIRE));
		apb(1'b1, OFS_TX, 32'h0000_003C);
		poll(STAT_TX_PEND, 1'b0);
		poll(STAT_FULL, 1'b0);
		apb(1'b1, OFS_CTRL, crecv);
		poll(STAT_RX_VALID, 1'b1);
		rdchk(OFS_RX, 32'h0000_005A);
		poll(STAT_RX_VALID, 1'b1);
		rdchk(OFS_RX, 32'h0000_00C3);
		poll(STAT_RX_VALID, 1'b1);
		rdchk(OFS_RX, 32'h0000_003C);
		poll(STAT_EMPTY, 1'b1);
		summarize();
	end
endmodule
